/* File: logic/sar_pkg.sv */
package sar_pkg;

    // Core clock rate, used to turn times into cycle counts
    localparam int unsigned CORE_CLK_MHZ = 125;

    // Internal conversion duration; plain default, no figure is given
    localparam int unsigned CONV_TIME_NS = 700;
    // Rounded up so a conversion never ends early
    localparam int unsigned CONV_CYCLES =
        (CONV_TIME_NS * CORE_CLK_MHZ + 999) / 1000;

    // Result word and readout frame lengths in serial-clock falling edges
    localparam int unsigned RESULT_BITS = 16;
    localparam int unsigned PLAIN_FRAME_EDGES = 16;
    localparam int unsigned BUSY_FRAME_EDGES = 17;

    // Width of the free-running falling-edge counter in the link domain
    localparam int unsigned EDGE_CNT_BITS = 10;

    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [EDGE_CNT_BITS-1:0] EDGE_CNT_RST = 10'h000;

    typedef enum logic [1:0] {
        SAR_ST_ACQ = 2'b00,
        SAR_ST_CONV = 2'b01,
        SAR_ST_READ = 2'b11
    } sar_state_t;

    typedef enum logic [1:0] {
        SAR_MODE_CS_PLAIN = 2'b00,
        SAR_MODE_CS_BUSY = 2'b01,
        SAR_MODE_DAISY = 2'b10
    } sar_mode_t;

    function automatic logic [EDGE_CNT_BITS-1:0] bin2gray(
        input logic [EDGE_CNT_BITS-1:0] b
    );
        return b ^ (b >> 1);
    endfunction : bin2gray

    function automatic logic [EDGE_CNT_BITS-1:0] gray2bin(
        input logic [EDGE_CNT_BITS-1:0] g
    );
        logic [EDGE_CNT_BITS-1:0] b;
        b = g;
        for (int i = EDGE_CNT_BITS - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : gray2bin

endpackage : sar_pkg

/* File: logic/sar_link_if.sv */
`timescale 1ns/1ps
interface sar_link_if #(
    parameter int unsigned CW = sar_pkg::EDGE_CNT_BITS
);
    // Gray-coded count of serial-clock falling edges
    logic [CW-1:0] edge_gray;
    // Chain input bit that is due on the output after the 16th edge
    logic chain_bit;

    modport link (
        output edge_gray,
        output chain_bit
    );

    modport core (
        input edge_gray,
        input chain_bit
    );
endinterface : sar_link_if

/* File: logic/sar_conv_timer.sv */
`timescale 1ns/1ps
module sar_conv_timer #(
    parameter int unsigned CYCLES = sar_pkg::CONV_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Control
    input wire logic start,
    // Status
    output logic running,
    output logic done
);
    localparam int unsigned TW = $clog2(CYCLES + 1);
    localparam logic [TW-1:0] LAST = TW'(CYCLES - 1);

    typedef struct packed {
        logic [TW-1:0] cnt;
        logic run;
        logic done;
    } sar_timer_t;

    sar_timer_t s_r;
    sar_timer_t s_nxt;

    // Runs on the core clock only, so serial pins cannot stretch it
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (start && !s_r.run) begin
            s_nxt.run = 1'b1;
            s_nxt.cnt = '0;
        end else if (s_r.run) begin
            if (s_r.cnt == LAST) begin
                s_nxt.run = 1'b0;
                s_nxt.done = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt + TW'(1);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign running = s_r.run;
    assign done = s_r.done;
endmodule : sar_conv_timer

/* File: logic/sar_sclk_side.sv */
`timescale 1ns/1ps
module sar_sclk_side #(
    parameter int unsigned CW = sar_pkg::EDGE_CNT_BITS
) (
    // Link clock and core reset level
    input wire logic sclk,
    input wire logic rst_n,
    // Chain data pin
    input wire logic serial_in,
    // Toward the core domain
    sar_link_if.link link
);
    typedef struct packed {
        logic rst_meta;
        logic rst_sync;
        logic [CW-1:0] cnt;
        logic [CW-1:0] gray;
        logic [15:0] hist;
    } sar_link_st_t;

    sar_link_st_t s_r;
    sar_link_st_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        // Reset release reaches this domain through two stages
        s_nxt.rst_meta = 1'b1;
        s_nxt.rst_sync = s_r.rst_meta;
        if (!s_r.rst_sync) begin
            s_nxt.cnt = sar_pkg::EDGE_CNT_RST;
            s_nxt.gray = sar_pkg::EDGE_CNT_RST;
            s_nxt.hist = sar_pkg::RESULT_RST;
        end else begin
            // Counter never clears; the core keeps its own base point
            s_nxt.cnt = s_r.cnt + CW'(1);
            s_nxt.gray = sar_pkg::bin2gray(s_nxt.cnt);
            s_nxt.hist = {s_r.hist[14:0], serial_in};
        end
    end

    // The shift happens on the falling edge of the serial clock.
    // The link clock is stopped in reset, so reset acts at once; release
    // costs two falls, which the host must give before the first frame.
    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{
                rst_meta: 1'b0,
                rst_sync: 1'b0,
                cnt: sar_pkg::EDGE_CNT_RST,
                gray: sar_pkg::EDGE_CNT_RST,
                hist: sar_pkg::RESULT_RST
            };
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.edge_gray = s_r.gray;
    assign link.chain_bit = s_r.hist[15];
endmodule : sar_sclk_side

/* File: logic/sar_readout.sv */
`timescale 1ns/1ps
module sar_readout #(
    parameter int unsigned CONV_CYCLES = sar_pkg::CONV_CYCLES,
    parameter int unsigned CW = sar_pkg::EDGE_CNT_BITS
) (
    // Clocks and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sclk,
    // Conversion control pins
    input wire logic conversion_trigger,
    input wire logic serial_in,
    // Serial output pin
    output logic sdo_o,
    output logic sdo_oe,
    // Converter array
    input wire logic [15:0] conv_result,
    output logic converter_on,
    output logic sample_hold,
    // Status
    output logic [1:0] mode_o,
    output logic result_ready,
    output logic daisy_clk_high
);
    localparam logic [CW-1:0] PLAIN_END = CW'(sar_pkg::PLAIN_FRAME_EDGES);
    localparam logic [CW-1:0] BUSY_END = CW'(sar_pkg::BUSY_FRAME_EDGES);
    localparam logic [CW-1:0] WORD_END = CW'(sar_pkg::RESULT_BITS);
    localparam logic [CW-1:0] ONE = CW'(1);

    typedef struct packed {
        logic trig_meta;
        logic trig_sync;
        logic trig_prev;
        logic din_meta;
        logic din_sync;
        logic din_prev;
        logic sclk_meta;
        logic sclk_sync;
        logic [CW-1:0] gray_meta;
        logic [CW-1:0] gray_sync;
        logic chain_meta;
        logic chain_sync;
        sar_pkg::sar_state_t st;
        sar_pkg::sar_mode_t mode;
        logic sclk_at_start;
        logic [15:0] result;
        logic [CW-1:0] base;
        logic frame_on;
        logic frame_done;
        logic sdo;
        logic sdo_oe;
        logic conv_on;
        logic ready;
    } sar_core_st_t;

    sar_core_st_t s_r;
    sar_core_st_t s_nxt;

    logic timer_start;
    logic timer_running;
    logic timer_done;

    sar_link_if #(.CW(CW)) link ();

    // Picks the bit that goes out after pos falling edges, MSB first
    function automatic logic pick_bit(
        input logic [15:0] word,
        input logic [CW-1:0] pos
    );
        logic [3:0] idx;
        idx = ~pos[3:0];
        return word[idx];
    endfunction : pick_bit

    sar_sclk_side #(
        .CW(CW)
    ) u_sclk_side (
        .sclk(sclk),
        .rst_n(rst_n),
        .serial_in(serial_in),
        .link(link.link)
    );

    sar_conv_timer #(
        .CYCLES(CONV_CYCLES)
    ) u_conv_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(timer_start),
        .running(timer_running),
        .done(timer_done)
    );

    logic trig_rise;
    logic din_fall;
    logic [CW-1:0] edges_now;
    logic [CW-1:0] pos_cur;

    // Edge detectors only look at second-stage synchroniser outputs
    assign trig_rise = s_r.trig_sync && !s_r.trig_prev;
    assign din_fall = !s_r.din_sync && s_r.din_prev;
    assign edges_now = sar_pkg::gray2bin(s_r.gray_sync);
    assign pos_cur = edges_now - s_r.base;
    // A new trigger is honoured only outside a running conversion
    assign timer_start = trig_rise && (s_r.st != sar_pkg::SAR_ST_CONV)
        && !timer_running;

    always_comb begin
        logic [CW-1:0] pos_nxt;
        pos_nxt = '0;
        s_nxt = s_r;

        // Pin and link inputs pass two flip-flops first
        s_nxt.trig_meta = conversion_trigger;
        s_nxt.trig_sync = s_r.trig_meta;
        s_nxt.trig_prev = s_r.trig_sync;
        s_nxt.din_meta = serial_in;
        s_nxt.din_sync = s_r.din_meta;
        s_nxt.din_prev = s_r.din_sync;
        s_nxt.sclk_meta = sclk;
        s_nxt.sclk_sync = s_r.sclk_meta;
        s_nxt.gray_meta = link.edge_gray;
        s_nxt.gray_sync = s_r.gray_meta;
        s_nxt.chain_meta = link.chain_bit;
        s_nxt.chain_sync = s_r.chain_meta;

        unique case (s_r.st)
            sar_pkg::SAR_ST_ACQ,
            sar_pkg::SAR_ST_READ: begin
                if (timer_start) begin
                    // Mode is chosen from the select level at this edge
                    s_nxt.st = sar_pkg::SAR_ST_CONV;
                    s_nxt.conv_on = 1'b1;
                    s_nxt.ready = 1'b0;
                    s_nxt.frame_on = 1'b0;
                    s_nxt.frame_done = 1'b0;
                    s_nxt.sclk_at_start = s_r.sclk_sync;
                    if (s_r.din_sync) begin
                        s_nxt.mode = sar_pkg::SAR_MODE_CS_PLAIN;
                    end else begin
                        s_nxt.mode = sar_pkg::SAR_MODE_DAISY;
                    end
                end else if (s_r.st == sar_pkg::SAR_ST_READ) begin
                    unique case (s_r.mode)
                        sar_pkg::SAR_MODE_CS_PLAIN: begin
                            if (!s_r.frame_on && !s_r.frame_done
                                && din_fall) begin
                                // Frame starts at the select fall
                                s_nxt.frame_on = 1'b1;
                                s_nxt.base = edges_now;
                            end else if (s_r.frame_on
                                && (pos_cur >= PLAIN_END
                                || s_r.din_sync)) begin
                                s_nxt.frame_on = 1'b0;
                                s_nxt.frame_done = 1'b1;
                            end
                        end
                        sar_pkg::SAR_MODE_CS_BUSY: begin
                            if (s_r.frame_on && (pos_cur >= BUSY_END
                                || s_r.din_sync)) begin
                                s_nxt.frame_on = 1'b0;
                                s_nxt.frame_done = 1'b1;
                            end
                        end
                        sar_pkg::SAR_MODE_DAISY: begin
                            // Chain frame lasts until the next trigger
                            s_nxt.frame_on = s_r.frame_on;
                        end
                        default: begin
                            s_nxt.frame_on = 1'b0;
                        end
                    endcase
                end
            end
            sar_pkg::SAR_ST_CONV: begin
                // Select level is ignored until the timer finishes
                if (timer_done) begin
                    s_nxt.st = sar_pkg::SAR_ST_READ;
                    s_nxt.conv_on = 1'b0;
                    s_nxt.ready = 1'b1;
                    s_nxt.result = conv_result;
                    s_nxt.base = edges_now;
                    if (s_r.mode == sar_pkg::SAR_MODE_DAISY) begin
                        s_nxt.frame_on = 1'b1;
                    end else if (!s_r.din_sync) begin
                        s_nxt.mode = sar_pkg::SAR_MODE_CS_BUSY;
                        s_nxt.frame_on = 1'b1;
                    end else begin
                        s_nxt.frame_on = 1'b0;
                    end
                end
            end
            default: begin
                s_nxt.st = sar_pkg::SAR_ST_ACQ;
                s_nxt.conv_on = 1'b0;
                s_nxt.frame_on = 1'b0;
            end
        endcase

        // Output bit is worked out from the next state so it never lags
        pos_nxt = edges_now - s_nxt.base;
        if (!s_r.trig_sync && !s_r.din_sync) begin
            s_nxt.sdo_oe = 1'b1;
            s_nxt.sdo = 1'b0;
        end else if (s_nxt.frame_on) begin
            s_nxt.sdo_oe = 1'b1;
            unique case (s_nxt.mode)
                sar_pkg::SAR_MODE_CS_PLAIN: begin
                    s_nxt.sdo = pick_bit(s_nxt.result, pos_nxt);
                end
                sar_pkg::SAR_MODE_CS_BUSY: begin
                    if (pos_nxt == '0) begin
                        s_nxt.sdo = 1'b0;
                    end else begin
                        s_nxt.sdo = pick_bit(s_nxt.result,
                            pos_nxt - ONE);
                    end
                end
                sar_pkg::SAR_MODE_DAISY: begin
                    if (pos_nxt < WORD_END) begin
                        s_nxt.sdo = pick_bit(s_nxt.result,
                            pos_nxt);
                    end else begin
                        // Bits from upstream devices follow our own word
                        s_nxt.sdo = s_r.chain_sync;
                    end
                end
                default: begin
                    s_nxt.sdo = 1'b0;
                end
            endcase
        end else begin
            s_nxt.sdo_oe = 1'b0;
            s_nxt.sdo = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_r <= '{
                trig_meta: 1'b0,
                trig_sync: 1'b0,
                trig_prev: 1'b0,
                din_meta: 1'b1,
                din_sync: 1'b1,
                din_prev: 1'b1,
                sclk_meta: 1'b0,
                sclk_sync: 1'b0,
                gray_meta: sar_pkg::EDGE_CNT_RST,
                gray_sync: sar_pkg::EDGE_CNT_RST,
                chain_meta: 1'b0,
                chain_sync: 1'b0,
                st: sar_pkg::SAR_ST_ACQ,
                mode: sar_pkg::SAR_MODE_CS_PLAIN,
                sclk_at_start: 1'b0,
                result: sar_pkg::RESULT_RST,
                base: sar_pkg::EDGE_CNT_RST,
                frame_on: 1'b0,
                frame_done: 1'b0,
                sdo: 1'b0,
                sdo_oe: 1'b0,
                conv_on: 1'b0,
                ready: 1'b0
            };
        end else begin
            s_r <= s_nxt;
        end
    end

    // Converter is powered only while a conversion runs
    assign converter_on = s_r.conv_on;
    assign sample_hold = s_r.conv_on;
    assign sdo_o = s_r.sdo;
    assign sdo_oe = s_r.sdo_oe;
    assign mode_o = s_r.mode;
    assign result_ready = s_r.ready;
    // Busy-bit daisy chain is not built; a high clock here is flagged
    assign daisy_clk_high = s_r.sclk_at_start
        && (s_r.mode == sar_pkg::SAR_MODE_DAISY);

endmodule : sar_readout

/* File: tb/sar_readout_asserts.sv */
`timescale 1ns/1ps
module sar_readout_asserts #(
    parameter int unsigned CONV_CYCLES = sar_pkg::CONV_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Pins
    input wire logic conversion_trigger,
    input wire logic serial_in,
    input wire logic sdo_o,
    input wire logic sdo_oe,
    // Converter and status
    input wire logic [15:0] conv_result,
    input wire logic converter_on,
    input wire logic sample_hold,
    input wire logic [1:0] mode_o,
    input wire logic result_ready
);
    logic [15:0] on_cnt_r;

    // Length of the conversion just ended, read when converter_on falls
    always_ff @(posedge core_clk) begin
        if (!rst_n || !converter_on) begin
            on_cnt_r <= 16'h0000;
        end else begin
            on_cnt_r <= on_cnt_r + 16'h0001;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    chk_off_in_conv: assert property (
        converter_on && conversion_trigger && $past(conversion_trigger, 3)
        |-> !sdo_oe) else $error("output on during conversion");
    chk_start_lat: assert property (
        $rose(conversion_trigger) && !converter_on |-> ##[2:6] converter_on)
        else $error("trigger did not start conversion");
    chk_conv_len: assert property (
        $fell(converter_on) |-> on_cnt_r == 16'(CONV_CYCLES)
        || on_cnt_r == 16'(CONV_CYCLES + 1)) else $error("bad conv length");
    chk_hold_same: assert property (
        sample_hold == converter_on) else $error("hold differs from conv");
    chk_ready_end: assert property (
        $fell(converter_on) |-> result_ready) else $error("no ready at end");
    chk_plain_quiet: assert property (
        $fell(converter_on) ##1 (mode_o == sar_pkg::SAR_MODE_CS_PLAIN)
        |-> !sdo_oe) else $error("plain mode drove output");
    chk_busy_low: assert property (
        $fell(converter_on) ##1 (mode_o == sar_pkg::SAR_MODE_CS_BUSY)
        |-> sdo_oe && !sdo_o) else $error("busy bit missing");
    chk_daisy_msb: assert property (
        $fell(converter_on) ##1 (mode_o == sar_pkg::SAR_MODE_DAISY)
        |-> sdo_oe && sdo_o == conv_result[15]) else $error("daisy msb bad");
    chk_mode_pick: assert property (
        $rose(converter_on) |=> mode_o[1] == !$past(serial_in, 2))
        else $error("wrong mode chosen");
    chk_both_low: assert property (
        (!conversion_trigger && !serial_in) [*4] |=> sdo_oe && !sdo_o)
        else $error("both low did not drive low");
    chk_sel_off: assert property (
        $rose(serial_in) && !mode_o[1] && !converter_on |-> ##[1:6] !sdo_oe)
        else $error("select rise left output on");

    cover property ($fell(converter_on) ##1 mode_o == 2'h0);
    cover property ($fell(converter_on) ##1 mode_o == 2'h1);
    cover property ($fell(converter_on) ##1 mode_o == 2'h2);
endmodule : sar_readout_asserts

bind sar_readout sar_readout_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_asserts (
    .core_clk(core_clk), .rst_n(rst_n),
    .conversion_trigger(conversion_trigger), .serial_in(serial_in),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .conv_result(conv_result),
    .converter_on(converter_on), .sample_hold(sample_hold),
    .mode_o(mode_o), .result_ready(result_ready)
);

/* File: tb/sar_host_model.sv */
`timescale 1ns/1ps
module sar_host_model (
    // Device serial output
    input wire logic sdo_o,
    input wire logic sdo_oe,
    // Serial clock, upstream chain bit, captured bits
    output logic sclk,
    output logic chain_out,
    output logic [31:0] cap_r
);
    logic last_r;
    logic line;
    logic [15:0] up_r;

    // A released line shows the inverse of its last level, not a held bit
    assign line = sdo_oe ? sdo_o : ~last_r;
    assign chain_out = up_r[15];

    initial begin
        sclk = 1'b0; // Idle low, so low at every trigger rise
        last_r = 1'b0;
        cap_r = '1;
        up_r = 16'h0000;
    end

    always @(sdo_o or sdo_oe) if (sdo_oe) last_r = sdo_o;

    // n falls of an 80 ns clock; capture at each fall
    task automatic burst(input int n, input logic [15:0] up);
        cap_r = '1;
        up_r = up;
        #3;
        for (int i = 0; i < n; i++) begin
            #40 sclk = 1'b1;
            if (i > 0) up_r = {up_r[14:0], 1'b0};
            #40 sclk = 1'b0;
            cap_r = {cap_r[30:0], line};
        end
    endtask : burst
endmodule : sar_host_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    localparam int unsigned CONV_N = 40;
    typedef struct {
        logic sel_trig;
        logic sel_end;
        logic [15:0] res;
        int falls;
        logic [15:0] up;
        logic [31:0] exp;
        logic [1:0] mode;
    } sar_row_t;

    logic core_clk, rst_n, conversion_trigger, sel_lvl, chain_on;
    logic serial_in, sclk, chain_out, sdo_o, sdo_oe;
    logic converter_on, sample_hold, result_ready, daisy_clk_high;
    logic [15:0] conv_result;
    logic [1:0] mode_o;
    logic [31:0] cap;
    int error_cnt, compares, cyc;

    sar_row_t rows [6] = '{
        '{1'h1, 1'h1, 16'ha5c3, 16, 16'h0, 32'hffffa5c3, 2'h0},
        '{1'h1, 1'h1, 16'h0000, 16, 16'h0, 32'hffff0000, 2'h0},
        '{1'h1, 1'h1, 16'h96e1, 8, 16'h0, 32'hffffff96, 2'h0},
        '{1'h1, 1'h0, 16'h8001, 17, 16'h0, 32'hfffe8001, 2'h1},
        '{1'h1, 1'h0, 16'h7f3c, 9, 16'h0, 32'hfffffe7f, 2'h1},
        '{1'h0, 1'h0, 16'h3c96, 32, 16'h5a0f, 32'h3c965a0f, 2'h2}};

    // Upstream device feeds serial_in only while reading a chain
    assign serial_in = chain_on ? chain_out : sel_lvl;

    sar_readout #(.CONV_CYCLES(CONV_N)) DUT (
        .core_clk(core_clk), .rst_n(rst_n), .sclk(sclk),
        .conversion_trigger(conversion_trigger), .serial_in(serial_in),
        .sdo_o(sdo_o), .sdo_oe(sdo_oe), .conv_result(conv_result),
        .converter_on(converter_on), .sample_hold(sample_hold),
        .mode_o(mode_o), .result_ready(result_ready),
        .daisy_clk_high(daisy_clk_high)
    );

    sar_host_model host (
        .sdo_o(sdo_o), .sdo_oe(sdo_oe), .sclk(sclk),
        .chain_out(chain_out), .cap_r(cap)
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step

    task automatic run_row(input sar_row_t r);
        int i;
        sel_lvl = r.sel_trig;
        conv_result = r.res;
        step(4);
        conversion_trigger = 1'b1; // Held through readout
        for (i = 0; i < 10 && converter_on !== 1'b1; i++) step(1);
        check(sdo_oe, 1'b0);
        // Select pulsed low mid-conversion, conversion must go on
        sel_lvl = 1'b0;
        step(3);
        sel_lvl = r.sel_end; // Settled before min time
        for (i = 0; i < 200 && result_ready !== 1'b1; i++) step(1);
        check(converter_on, 1'b0);
        check(mode_o, r.mode);
        check({sdo_oe, sdo_oe & sdo_o},
            r.mode == 2'h0 ? 2'b00 : {1'b1, r.mode[1] & r.res[15]});
        if (r.mode == 2'h0) begin
            sel_lvl = 1'b0; // Previous output already off
            step(8);
            check({sdo_oe, sdo_o}, {1'b1, r.res[15]});
        end
        if (r.mode == 2'h2) check(daisy_clk_high, 1'b0);
        chain_on = r.mode[1];
        host.burst(r.falls, r.up);
        step(8);
        check(cap, r.exp);
        if (r.mode != 2'h2) begin
            check(sdo_oe, r.falls < 16 + r.mode[0]);
        end
        sel_lvl = 1'b1;
        chain_on = 1'b0;
        step(8);
        if (r.mode != 2'h2) check(sdo_oe, 1'b0);
        conversion_trigger = 1'b0;
        step(6);
    endtask : run_row

    initial begin
        rst_n = 1'b1;
        conversion_trigger = 1'b0;
        sel_lvl = 1'b1;
        chain_on = 1'b0;
        conv_result = 16'h0000;
        error_cnt = 0;
        compares = 0;
        cyc = 0;
        // Reset falls after time zero so the link side sees a clean edge
        step(0);
        rst_n = 1'b0;
        step(10);
        check({sdo_oe, converter_on, result_ready, mode_o}, 5'h00);
        rst_n = 1'b1;
        step(2);
        // Two idle falls let the link-side reset release settle
        host.burst(2, 16'h0000);
        foreach (rows[k]) run_row(rows[k]);
        sel_lvl = 1'b0;
        step(6);
        check({sdo_oe, sdo_o}, 2'b10);
        sel_lvl = 1'b1;
        step(6);
        print_verdict();
    end
endmodule : tb_top
